// File: core/nsc_pkg.sv
// constants, types and the checksum step for the network status/command bank
// assumes a 25 MHz system clock and an 8N1 serial line to the network master
package nsc_pkg;

  // clock and serial line
  localparam logic [31:0] CLK_HZ       = 32'h017D_7840; // 25 MHz
  localparam logic [31:0] BAUD_DEF     = 32'h0000_2580; // 9600 baud
  localparam logic [3:0]  FRAME_BITS   = 4'h9;          // start, 8 data, stop: last index
  localparam logic [31:0] SILENCE_BITS = 32'h0000_0024; // 3.5 chars of 10 bits plus one bit
  localparam logic [7:0]  SLAVE_ID_DEF = 8'h01;         // arbitrary station number
  localparam logic [7:0]  BCAST_ID     = 8'h00;

  // section base addresses, set by the connection setup
  localparam logic [15:0] OUT_BASE_DEF = 16'h0000;
  localparam logic [15:0] IN_BASE_DEF  = 16'h0000;
  localparam logic [4:0]  WORD_COUNT   = 5'h08;

  // output word offsets
  localparam logic [2:0]  OFS_RUN_STATE = 3'h0;
  localparam logic [2:0]  OFS_POWER     = 3'h1;
  localparam logic [2:0]  OFS_FAULT     = 3'h2;
  localparam logic [2:0]  OFS_CAPACITY  = 3'h3;
  localparam logic [2:0]  OFS_VOLTAGE   = 3'h4;
  localparam logic [2:0]  OFS_CURRENT   = 3'h5;
  localparam logic [2:0]  OFS_PF        = 3'h6;
  localparam logic [2:0]  OFS_ENABLE    = 3'h7;
  // input word offset
  localparam logic [2:0]  OFS_RUN_CMD   = 3'h0;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  // function and exception codes
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT = 8'h04;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_ERR_BIT    = 8'h80;
  localparam logic [7:0]  EX_NONE       = 8'h00;
  localparam logic [7:0]  EX_BAD_FUNC   = 8'h01;
  localparam logic [7:0]  EX_BAD_ADDR   = 8'h02;

  // frame lengths in bytes
  localparam logic [3:0]  REQ_LEN      = 4'h8;
  localparam logic [4:0]  RSP_FIXED    = 5'h05;
  localparam logic [4:0]  ECHO_LEN     = 5'h08;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [15:0] CRC_GOOD     = 16'h0000;

  // fault code for a dead converter link (7010)
  localparam logic [15:0] FAULT_CODE_COMM = 16'h1B62;
  localparam logic [15:0] FAULT_CODE_NONE = 16'h0000;

  // long times and their cycle counts
  localparam int unsigned CNT_W         = 40;
  localparam logic [39:0] MS_PER_S      = 40'h00_0000_03E8;
  localparam logic [39:0] DISPLAY_IDLE_S = 40'h00_0000_012C; // 5 minutes
  localparam logic [39:0] LINK_TIMEOUT_MS = 40'h00_0000_0064; // 100 ms
  localparam logic [39:0] LED_HOLD_MS   = 40'h00_0000_000A;   // 10 ms
  localparam logic [39:0] DISPLAY_IDLE_CYC = DISPLAY_IDLE_S * 40'(CLK_HZ);
  localparam logic [39:0] LINK_TIMEOUT_CYC = LINK_TIMEOUT_MS * 40'(CLK_HZ) / MS_PER_S;
  localparam logic [39:0] LED_HOLD_CYC  = LED_HOLD_MS * 40'(CLK_HZ) / MS_PER_S;

  typedef enum logic [0:0] {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } nsc_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b10
  } nsc_tx_state_t;

  // one byte through the reflected 0xA001 checksum
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

endpackage : nsc_pkg

// File: core/nsc_regs.sv
// network status/command register bank with its serial slave, local gating,
// fault latch, display idle timer and board indicators
// assumes all inputs synchronous to mclk_i; the line driver is half duplex
//
// Notes on behaviour
// - registers reached through a built-in serial RTU slave on the line pins
// - every network word is sixteen bits, one offset per whole word
// - output word 0 reads 0 while running, 1 while idle
// - output word 1 reads 1 with input power present, else 0
// - output word 2 reads 1 while faulted, else 0
// - output word 3 reads 1 at maximum current, else 0
// - output words 4 and 5 carry RMS line voltage and line current
// - output word 6 carries signed power factor times one thousand
// - output word 7 reads 1 while remote run commands are permitted
// - remote command acts only while the local enable is set
// - local panel stop clears the enable, blocking later remote runs
// - fault clears on panel fault reset or on panel stop
// - display blanks after five idle minutes and wakes on a touch
// - dead converter link raises communications fault code 7010
// - indicators for each relay, link traffic each way, run command present
`timescale 1ns/1ps

module nsc_regs #(
  parameter logic [31:0] BAUD         = nsc_pkg::BAUD_DEF,
  parameter logic [7:0]  SLAVE_ID     = nsc_pkg::SLAVE_ID_DEF,
  parameter logic [15:0] OUT_BASE     = nsc_pkg::OUT_BASE_DEF,
  parameter logic [15:0] IN_BASE      = nsc_pkg::IN_BASE_DEF,
  parameter logic [39:0] IDLE_CYC     = nsc_pkg::DISPLAY_IDLE_CYC,
  parameter logic [39:0] LINK_TO_CYC  = nsc_pkg::LINK_TIMEOUT_CYC,
  parameter logic [39:0] LED_HOLD_CYC = nsc_pkg::LED_HOLD_CYC,
  parameter logic [39:0] SILENCE_CYC  = nsc_pkg::SILENCE_BITS * 40'(nsc_pkg::CLK_HZ / BAUD)
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // serial line to the network master
  input  wire logic        line_rx_i,
  output logic             line_tx_o,
  output logic             line_de_o,
  // filter status
  input  wire logic        filter_running_i,
  input  wire logic        power_present_i,
  input  wire logic        fault_event_i,
  input  wire logic        at_capacity_i,
  input  wire logic [15:0] line_voltage_i,
  input  wire logic [15:0] line_current_i,
  input  wire logic [15:0] power_factor_i,
  // operator panel
  input  wire logic        panel_stop_i,
  input  wire logic        panel_fault_reset_i,
  input  wire logic        panel_enable_set_i,
  input  wire logic        panel_touch_i,
  // converter link activity
  input  wire logic        conv_rx_i,
  input  wire logic        conv_tx_i,
  // results
  output logic             run_request_o,
  output logic             remote_enable_o,
  output logic             fault_o,
  output logic             comm_fault_o,
  output logic [15:0]      fault_code_o,
  output logic             display_on_o,
  // board indicators
  output logic             led_running_o,
  output logic             led_power_o,
  output logic             led_fault_o,
  output logic             led_limit_o,
  output logic             led_conv_rx_o,
  output logic             led_conv_tx_o,
  output logic             led_run_cmd_o
);

  localparam logic [15:0] BIT_CYC  = 16'(nsc_pkg::CLK_HZ / BAUD);
  localparam logic [15:0] HALF_CYC = 16'(nsc_pkg::CLK_HZ / BAUD / 32'h0000_0002);

  nsc_pkg::nsc_rx_state_t rx_state;
  nsc_pkg::nsc_tx_state_t tx_state;
  logic [15:0] rx_cyc;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_valid;
  logic [39:0] quiet_cnt;
  logic        frame_end;
  logic [7:0]  buf_mem [8];
  logic [3:0]  buf_cnt;
  logic [15:0] rx_crc;
  logic [15:0] cmd;
  logic        remote_enable;
  logic [15:0] out_w [8];
  // request decode
  logic [15:0] req_addr;
  logic [15:0] req_qty;
  logic [15:0] req_off;
  logic        req_ok;
  logic        req_bcast;
  logic [7:0]  req_exc;
  logic [4:0]  req_len;
  logic        req_write;
  // response
  logic [7:0]  rsp_fc;
  logic [7:0]  rsp_exc;
  logic [2:0]  rsp_off;
  logic [3:0]  rsp_qty;
  logic [4:0]  rsp_len;
  logic [4:0]  tx_idx;
  logic [15:0] tx_crc;
  logic [15:0] tx_cyc;
  logic [3:0]  tx_bit;
  logic [9:0]  tx_shift;
  logic [7:0]  tx_byte;
  logic [2:0]  tx_woff;
  logic [15:0] tx_word;
  // local side
  logic [39:0] idle_cnt;
  logic [39:0] conv_rx_quiet;
  logic [39:0] conv_tx_quiet;
  logic        conv_rx_q;
  logic        conv_tx_q;
  logic        link_dead;

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver, sampled mid bit
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state <= nsc_pkg::RX_IDLE;
      rx_cyc   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      unique case (rx_state)
        nsc_pkg::RX_IDLE: begin
          // half duplex: own transmission is not heard
          if (!line_rx_i && tx_state == nsc_pkg::TX_IDLE) begin
            rx_state <= nsc_pkg::RX_BITS;
            rx_cyc   <= HALF_CYC;
            rx_bit   <= 4'h0;
          end
        end
        nsc_pkg::RX_BITS: begin
          if (rx_cyc != 16'h0000) begin
            rx_cyc <= rx_cyc - 16'h0001;
          end else begin
            rx_cyc <= BIT_CYC - 16'h0001;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && line_rx_i) begin
              rx_state <= nsc_pkg::RX_IDLE; // glitch, not a start bit
            end else if (rx_bit == nsc_pkg::FRAME_BITS) begin
              rx_state <= nsc_pkg::RX_IDLE;
              rx_valid <= line_rx_i; // bad stop bit drops the byte
            end else if (rx_bit != 4'h0) begin
              rx_shift <= {line_rx_i, rx_shift[7:1]};
            end
          end
        end
      endcase
    end
  end

  // line silence marks the end of a frame
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet_cnt <= 40'h00_0000_0000;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (!line_rx_i || rx_state != nsc_pkg::RX_IDLE) begin
        quiet_cnt <= 40'h00_0000_0000;
      end else if (quiet_cnt != SILENCE_CYC) begin
        quiet_cnt <= quiet_cnt + 40'h00_0000_0001;
        frame_end <= (quiet_cnt == SILENCE_CYC - 40'h00_0000_0001) && buf_cnt != 4'h0;
      end
    end
  end

  // frame store and running checksum; overlong frames saturate and fail
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_cnt <= 4'h0;
      rx_crc  <= nsc_pkg::CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (frame_end) begin
      buf_cnt <= 4'h0;
      rx_crc  <= nsc_pkg::CRC_INIT;
    end else if (rx_valid) begin
      if (buf_cnt < nsc_pkg::REQ_LEN) begin
        buf_mem[buf_cnt[2:0]] <= rx_shift;
      end
      if (buf_cnt <= nsc_pkg::REQ_LEN) begin
        buf_cnt <= buf_cnt + 4'h1;
      end
      rx_crc <= nsc_pkg::crc_step(rx_crc, rx_shift);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status words, all sixteen bits wide
  always_comb begin
    out_w[nsc_pkg::OFS_RUN_STATE] = {15'h0000, !filter_running_i};
    out_w[nsc_pkg::OFS_POWER]     = {15'h0000, power_present_i};
    out_w[nsc_pkg::OFS_FAULT]     = {15'h0000, fault_o};
    out_w[nsc_pkg::OFS_CAPACITY]  = {15'h0000, at_capacity_i};
    out_w[nsc_pkg::OFS_VOLTAGE]   = line_voltage_i;
    out_w[nsc_pkg::OFS_CURRENT]   = line_current_i;
    out_w[nsc_pkg::OFS_PF]        = power_factor_i;  // signed, x1000
    out_w[nsc_pkg::OFS_ENABLE]    = {15'h0000, remote_enable};
  end

  // request check: address, function, range against the configured bases
  always_comb begin
    req_addr  = {buf_mem[2], buf_mem[3]};
    req_qty   = {buf_mem[4], buf_mem[5]};
    req_bcast = buf_mem[0] == nsc_pkg::BCAST_ID;
    req_ok    = buf_cnt == nsc_pkg::REQ_LEN && rx_crc == nsc_pkg::CRC_GOOD
                && (buf_mem[0] == SLAVE_ID || req_bcast);
    req_write = 1'b0;
    req_off   = req_addr - ((buf_mem[1] == nsc_pkg::FC_READ_INPUT) ? OUT_BASE : IN_BASE);
    req_exc   = nsc_pkg::EX_NONE;
    req_len   = nsc_pkg::RSP_FIXED;
    unique case (buf_mem[1])
      nsc_pkg::FC_READ_HOLD, nsc_pkg::FC_READ_INPUT: begin
        if (req_qty == 16'h0000 || req_addr < ((buf_mem[1] == nsc_pkg::FC_READ_INPUT)
            ? OUT_BASE : IN_BASE) || 17'(req_off) + 17'(req_qty) > 17'(nsc_pkg::WORD_COUNT)) begin
          req_exc = nsc_pkg::EX_BAD_ADDR;
        end else begin
          req_len = nsc_pkg::RSP_FIXED + {req_qty[3:0], 1'b0};
        end
      end
      nsc_pkg::FC_WRITE_ONE: begin
        if (req_addr < IN_BASE || req_off >= 16'(nsc_pkg::WORD_COUNT)) begin
          req_exc = nsc_pkg::EX_BAD_ADDR;
        end else begin
          req_write = 1'b1;
          req_len   = nsc_pkg::ECHO_LEN;
        end
      end
      default: req_exc = nsc_pkg::EX_BAD_FUNC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // local enable: set from the panel, cleared by a panel stop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remote_enable <= 1'b0;
    end else if (panel_stop_i) begin
      remote_enable <= 1'b0;
    end else if (panel_enable_set_i) begin
      remote_enable <= 1'b1;
    end
  end

  // command word: only offset 0 stores; a stop also drops a stale run
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd <= nsc_pkg::CMD_RESET;
    end else if (panel_stop_i) begin
      cmd <= nsc_pkg::CMD_RESET;
    end else if (frame_end && req_ok && req_write && remote_enable
                 && req_off[2:0] == nsc_pkg::OFS_RUN_CMD) begin
      cmd <= req_qty; // value field of a single write
    end
  end

  assign run_request_o   = remote_enable && cmd[0];
  assign remote_enable_o = remote_enable;

  ////////////////////////////////////////////////////////////////////////////
  // response parameters latched at frame end; broadcasts get no answer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_fc  <= 8'h00;
      rsp_exc <= nsc_pkg::EX_NONE;
      rsp_off <= 3'h0;
      rsp_qty <= 4'h0;
      rsp_len <= 5'h00;
    end else if (frame_end && req_ok) begin
      rsp_fc  <= (req_exc != nsc_pkg::EX_NONE) ? (buf_mem[1] | nsc_pkg::FC_ERR_BIT) : buf_mem[1];
      rsp_exc <= req_exc;
      rsp_off <= req_off[2:0];
      rsp_qty <= req_qty[3:0];
      rsp_len <= req_len;
    end
  end

  // byte to send at tx_idx; checksum bytes come last, low byte first
  always_comb begin
    tx_woff = rsp_off + 3'((tx_idx - 5'h03) >> 1);
    if (rsp_fc == nsc_pkg::FC_READ_INPUT) begin
      tx_word = out_w[tx_woff];
    end else begin
      tx_word = (tx_woff == nsc_pkg::OFS_RUN_CMD) ? cmd : nsc_pkg::WORD_ZERO;
    end
    if (tx_idx == rsp_len - 5'h02) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx == rsp_len - 5'h01) begin
      tx_byte = tx_crc[15:8];
    end else if (tx_idx == 5'h00) begin
      tx_byte = SLAVE_ID;
    end else if (tx_idx == 5'h01) begin
      tx_byte = rsp_fc;
    end else if (rsp_exc != nsc_pkg::EX_NONE) begin
      tx_byte = rsp_exc;
    end else if (rsp_fc == nsc_pkg::FC_WRITE_ONE) begin
      tx_byte = buf_mem[tx_idx[2:0]];
    end else if (tx_idx == 5'h02) begin
      tx_byte = {3'h0, rsp_qty, 1'b0};
    end else begin
      tx_byte = tx_idx[0] ? tx_word[15:8] : tx_word[7:0]; // high byte first
    end
  end

  // transmitter; driver enable spans the whole answer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state <= nsc_pkg::TX_IDLE;
      tx_idx   <= 5'h00;
      tx_crc   <= nsc_pkg::CRC_INIT;
      tx_cyc   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_shift <= 10'h3FF;
    end else begin
      unique case (tx_state)
        nsc_pkg::TX_IDLE: begin
          if (frame_end && req_ok && !req_bcast) begin
            tx_state <= nsc_pkg::TX_LOAD;
            tx_idx   <= 5'h00;
            tx_crc   <= nsc_pkg::CRC_INIT;
          end
        end
        nsc_pkg::TX_LOAD: begin
          tx_shift <= {1'b1, tx_byte, 1'b0};
          tx_cyc   <= BIT_CYC - 16'h0001;
          tx_bit   <= 4'h0;
          tx_state <= nsc_pkg::TX_SEND;
          if (tx_idx < rsp_len - 5'h02) begin
            tx_crc <= nsc_pkg::crc_step(tx_crc, tx_byte);
          end
        end
        nsc_pkg::TX_SEND: begin
          if (tx_cyc != 16'h0000) begin
            tx_cyc <= tx_cyc - 16'h0001;
          end else if (tx_bit != nsc_pkg::FRAME_BITS) begin
            tx_cyc   <= BIT_CYC - 16'h0001;
            tx_bit   <= tx_bit + 4'h1;
            tx_shift <= {1'b1, tx_shift[9:1]};
          end else if (tx_idx == rsp_len - 5'h01) begin
            tx_state <= nsc_pkg::TX_IDLE;
            tx_shift <= 10'h3FF;
          end else begin
            tx_idx   <= tx_idx + 5'h01;
            tx_state <= nsc_pkg::TX_LOAD;
          end
        end
        default: tx_state <= nsc_pkg::TX_IDLE;
      endcase
    end
  end

  assign line_tx_o = tx_shift[0];
  assign line_de_o = tx_state != nsc_pkg::TX_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // converter link watch: quiet counters on each direction's edges
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_rx_q     <= 1'b1;
      conv_tx_q     <= 1'b1;
      conv_rx_quiet <= 40'h00_0000_0000;
      conv_tx_quiet <= 40'h00_0000_0000;
    end else begin
      conv_rx_q <= conv_rx_i;
      conv_tx_q <= conv_tx_i;
      conv_rx_quiet <= (conv_rx_q != conv_rx_i) ? 40'h00_0000_0000
                     : (conv_rx_quiet == LINK_TO_CYC) ? conv_rx_quiet
                     : conv_rx_quiet + 40'h00_0000_0001;
      conv_tx_quiet <= (conv_tx_q != conv_tx_i) ? 40'h00_0000_0000
                     : (conv_tx_quiet == LINK_TO_CYC) ? conv_tx_quiet
                     : conv_tx_quiet + 40'h00_0000_0001;
    end
  end

  assign link_dead = conv_rx_quiet == LINK_TO_CYC;

  // fault latch: an event in the clearing cycle still sets it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_o      <= 1'b0;
      comm_fault_o <= 1'b0;
      fault_code_o <= nsc_pkg::FAULT_CODE_NONE;
    end else if (link_dead) begin
      fault_o      <= 1'b1;
      comm_fault_o <= 1'b1;
      fault_code_o <= nsc_pkg::FAULT_CODE_COMM;
    end else if (fault_event_i) begin
      fault_o <= 1'b1;
    end else if (panel_fault_reset_i || panel_stop_i) begin
      fault_o      <= 1'b0;
      comm_fault_o <= 1'b0;
      fault_code_o <= nsc_pkg::FAULT_CODE_NONE;
    end
  end

  // display idle timer; a touch restarts it and wakes the screen
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt <= 40'h00_0000_0000;
    end else if (panel_touch_i) begin
      idle_cnt <= 40'h00_0000_0000;
    end else if (idle_cnt != IDLE_CYC) begin
      idle_cnt <= idle_cnt + 40'h00_0000_0001;
    end
  end

  assign display_on_o = idle_cnt != IDLE_CYC;

  // indicators; traffic lamps held on briefly so single bytes show
  assign led_running_o = filter_running_i;
  assign led_power_o   = power_present_i;
  assign led_fault_o   = fault_o;
  assign led_limit_o   = at_capacity_i;
  assign led_conv_rx_o = conv_rx_quiet < LED_HOLD_CYC;
  assign led_conv_tx_o = conv_tx_quiet < LED_HOLD_CYC;
  assign led_run_cmd_o = run_request_o;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  enable_clear_a: assert property (panel_stop_i |=> !remote_enable_o && !run_request_o)
    else $error("remote enable survived a panel stop");
  run_gate_a: assert property (!remote_enable_o |-> !run_request_o)
    else $error("run requested while remote enable is off");
  cmd_hold_a: assert property (!remote_enable_o |=> $stable(cmd))
    else $error("command word changed while disabled");
  fault_set_a: assert property (fault_event_i |=> fault_o && led_fault_o)
    else $error("fault event lost");
  fault_clear_a: assert property ((panel_fault_reset_i || panel_stop_i) && !fault_event_i
                                   && !link_dead |=> !fault_o)
    else $error("fault not cleared by panel action");
  display_wake_a: assert property (panel_touch_i |=> display_on_o [*8])
    else $error("display not awake after touch");
  comm_code_a: assert property (link_dead |=> comm_fault_o && fault_code_o == 16'h1B62)
    else $error("link loss did not raise code 7010");
  line_idle_a: assert property (!line_de_o |-> line_tx_o)
    else $error("line driven low while driver disabled");
  run_word_a: assert property (out_w[nsc_pkg::OFS_RUN_STATE] == {15'h0000, !led_running_o})
    else $error("run state word does not follow running state");

endmodule : nsc_regs

// File: tb/nsc_master.sv
// network master model: sends rtu requests, decodes the slave's replies
// assumes 8n1 at BIT clock cycles a bit, line idles high
`timescale 1ns/1ps
module nsc_master #(parameter int BIT = 10) (
  // clock and slave transmit line
  input  wire logic       mclk_i,
  input  wire logic       tx_i,
  // request line and decoded reply bytes
  output logic            rx_o,
  output logic            got_o,
  output logic [7:0]      byte_o
);
  // reflected checksum, kept apart from the design's own step
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    c ^= {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction : crc
  // whole bytes, checksum low byte first, bits lsb first off the sampling edge
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [9:0]  f;
    c = 16'hFFFF;
    foreach (q[i]) c = crc(c, q[i]);
    q = {q, c[7:0], c[15:8]};
    foreach (q[i]) begin
      f = {1'b1, q[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(negedge mclk_i) rx_o = f[b];
        repeat (BIT - 1) @(negedge mclk_i);
      end
    end
  endtask : send
  // sample reply bits mid-cell; one strobe per byte
  initial begin
    rx_o = 1'b1;
    got_o = 1'b0;
    byte_o = 8'h00;
    forever begin
      @(negedge tx_i);
      repeat (BIT / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk_i);
        byte_o[i] = tx_i;
      end
      repeat (BIT) @(posedge mclk_i);
      got_o = 1'b1;
      @(posedge mclk_i) got_o = 1'b0;
    end
  end
endmodule : nsc_master

// File: tb/test_nsc_regs.sv
// self-checking bench for the network status/command bank
// assumes the master model on the line and shortened counts
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module test_nsc_regs;
  logic mclk_i = '0, rst_b_i = '0, line_rx_i, line_tx_o, line_de_o, got, link_on = '1;
  logic filter_running_i = '0, power_present_i = '0, fault_event_i = '0, at_capacity_i = '0;
  logic panel_stop_i = '0, panel_fault_reset_i = '0, panel_enable_set_i = '0;
  logic panel_touch_i = '0, conv_rx_i = '1, conv_tx_i = '1, run_request_o, remote_enable_o;
  logic fault_o, comm_fault_o, display_on_o, led_running_o, led_power_o, led_fault_o;
  logic led_limit_o, led_conv_rx_o, led_conv_tx_o, led_run_cmd_o;
  logic [15:0] line_voltage_i = '0, line_current_i = '0, power_factor_i = '0, fault_code_o, w[8];
  logic [7:0]  rx_b, eb, exp_q[$];
  logic [31:0] seed = 32'h0000_BCB8;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  nsc_regs #(.BAUD(32'h0026_25A0), .IDLE_CYC(40'h00_0000_00C8), .LINK_TO_CYC(40'h00_0000_0064),
    .LED_HOLD_CYC(40'h00_0000_000A), .SILENCE_CYC(40'h00_0000_0028)) dut (.*);
  nsc_master #(.BIT(10)) pm (.mclk_i(mclk_i), .tx_i(line_tx_o), .rx_o(line_rx_i), .got_o(got),
    .byte_o(rx_b));
  // clock, converter traffic both ways, hang guard
  always #20 mclk_i = ~mclk_i;
  always begin
    repeat (10) @(negedge mclk_i);
    if (link_on) begin
      conv_rx_i = ~conv_rx_i;
      conv_tx_i = ~conv_tx_i;
    end
  end
  always @(posedge mclk_i) if (++cyc == 40000) begin fail_count++; final_report(); end
  // each reply byte against the oldest note
  always @(posedge got) begin
    eb = exp_q.size() ? exp_q.pop_front() : 8'hxx;
    `CHK("reply byte", eb, rx_b)
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // send a request, note its reply with checksum, wait bounded
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] r[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (r[i]) c = pm.crc(c, r[i]);
    exp_q = {exp_q, r, c[7:0], c[15:8]};
    pm.send(q);
    for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(negedge mclk_i);
    repeat (20) @(negedge mclk_i);
    `CHK("reply left", 0, exp_q.size())
  endtask : xfer
  task automatic rd8(input logic [7:0] fc);
    logic [7:0] r[$];
    r = '{8'h01, fc, 8'h10};
    foreach (w[i]) r = {r, w[i][15:8], w[i][7:0]};
    xfer('{8'h01, fc, 8'h00, 8'h00, 8'h00, 8'h08}, r);
  endtask : rd8
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q[$];
    q = '{8'h01, 8'h06, 8'h00, a, v[15:8], v[7:0]};
    xfer(q, q);
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge mclk_i) s = 1'b1;
    @(negedge mclk_i) s = 1'b0;
    @(negedge mclk_i);
  endtask : pulse
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (2) begin
      filter_running_i = 1'(rnd());
      power_present_i = 1'(rnd());
      at_capacity_i = 1'(rnd());
      line_voltage_i = 16'(rnd());
      line_current_i = 16'(rnd());
      power_factor_i = 16'(rnd());
      w = '{{15'h0, ~filter_running_i}, {15'h0, power_present_i}, 16'h0000,
        {15'h0, at_capacity_i}, line_voltage_i, line_current_i, power_factor_i, 16'h0000};
      rd8(8'h04);
      `CHK("run led", filter_running_i, led_running_o)
      `CHK("limit led", at_capacity_i, led_limit_o)
      `CHK("power led", power_present_i, led_power_o)
    end
    wr(8'h00, 16'h0001);
    `CHK("blocked", 1'b0, run_request_o)
    pulse(panel_enable_set_i);
    `CHK("enable", 1'b1, remote_enable_o)
    wr(8'h00, 16'h0001);
    `CHK("run", 1'b1, run_request_o)
    `CHK("cmd led", 1'b1, led_run_cmd_o)
    wr(8'h03, 16'h1234);
    w = '{0: 16'h0001, default: 16'h0000};
    rd8(8'h03);
    pulse(panel_stop_i);
    `CHK("stop en", 1'b0, remote_enable_o)
    pulse(panel_enable_set_i);
    `CHK("no restart", 1'b0, run_request_o)
    // broadcast write acts but is never answered
    pm.send('{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h01});
    repeat (60) @(negedge mclk_i);
    `CHK("bcast run", 1'b1, run_request_o)
    `CHK("bcast quiet", 1'b0, line_de_o)
    pulse(fault_event_i);
    `CHK("fault led", 1'b1, led_fault_o)
    w = '{{15'h0, ~filter_running_i}, {15'h0, power_present_i}, 16'h0001,
      {15'h0, at_capacity_i}, line_voltage_i, line_current_i, power_factor_i, 16'h0001};
    rd8(8'h04);
    pulse(panel_fault_reset_i);
    `CHK("fault reset", 1'b0, fault_o)
    pulse(fault_event_i);
    pulse(panel_stop_i);
    `CHK("fault stop", 1'b0, fault_o)
    xfer('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h87, 8'h01});
    xfer('{8'h01, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h02});
    pulse(panel_touch_i);
    repeat (190) @(negedge mclk_i);
    `CHK("awake", 1'b1, display_on_o)
    repeat (15) @(negedge mclk_i);
    `CHK("blank", 1'b0, display_on_o)
    pulse(panel_touch_i);
    `CHK("wake", 1'b1, display_on_o)
    link_on = 1'b0;
    repeat (30) @(negedge mclk_i);
    `CHK("link led", 1'b0, led_conv_rx_o)
    `CHK("tx led", 1'b0, led_conv_tx_o)
    repeat (100) @(negedge mclk_i);
    `CHK("code", 16'h1B62, fault_code_o)
    `CHK("comm set", 1'b1, comm_fault_o)
    link_on = 1'b1;
    repeat (30) @(negedge mclk_i);
    pulse(panel_fault_reset_i);
    `CHK("comm clear", 1'b0, comm_fault_o)
    final_report();
  end
endmodule : test_nsc_regs
